// ---- rtl/sphp_spi_slave.sv ----
// Slave serial port with pending-data alert, fill byte, padding and port selection
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Port works only as slave; clock and input data come from master.
// - Four lines: data in, data out, serial clock, slave select.
// - Alert asserted while data waits, held until all bytes shifted out.
// - Serial clock and data rate at most 5 Mb/s.
// - Bytes shift most significant bit first on both lines.
// - Mode 0: clock idles low, data sampled on rising edge.
// - Only framed protocol; framed setting must be one when used.
// - With select asserted, shift in received bits and present transmit bits.
// - Rising edge of select resets receive and transmit shift registers.
// - Output line driven whenever serial clock toggles, select or not.
// - With nothing queued, send busy fill byte per clocked byte.
// - Data into empty transmit buffer is preceded by one padding byte.
// - Both ports enabled: async until first select, then sync till reset.
// - Only async enabled: use it alone, ignore select.
// - Only sync enabled: use it alone, ignore async traffic.
// - Async output held low at boot forces sync port only.
// - Neither enabled: async stays enabled and alone, select ignored.
module sphp_spi_slave
  import sphp_pkg::*;
#(
  parameter int DEPTH = SPHP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Serial pins
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic ssel_n_in,
  output logic miso_out,
  output logic miso_oe_out,
  output logic data_pending_alert_n_out,
  // Configuration
  input wire logic [1:0] port_enable_in,
  input wire logic async_dout_pin_in,
  input wire logic framed_protocol_setting_in,
  // Transmit data from device core
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  // Received data to device core
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  // Port selection status
  output logic sync_active_out,
  output logic async_active_out
);
  // Below two the pad byte could not lead the data
  if (DEPTH < 2) begin : g_depth_check
    $error("DEPTH too small");
  end

  // Pin synchronisers
  logic sclk_s;
  logic mosi_s;
  logic ssel_n_s;
  logic dout_s;
  sphp_sync2 #(.RESET_VAL(1'b0)) u_sync_sclk (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .d_in(sclk_in), .q_out(sclk_s));
  sphp_sync2 #(.RESET_VAL(1'b0)) u_sync_mosi (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .d_in(mosi_in), .q_out(mosi_s));
  sphp_sync2 #(.RESET_VAL(1'b1)) u_sync_ssel (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .d_in(ssel_n_in), .q_out(ssel_n_s));
  sphp_sync2 #(.RESET_VAL(1'b1)) u_sync_dout (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .d_in(async_dout_pin_in), .q_out(dout_s));

  // Edge detection on synchronised pins
  logic sclk_d;
  logic ssel_n_d;
  logic sclk_rise;
  logic sclk_fall;
  logic ssel_rise;
  logic ssel_fall;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_d <= 1'b0;
      ssel_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      ssel_n_d <= ssel_n_s;
    end
  end
  // Edges need half periods of several clocks; the clock ratio caps the link rate
  assign sclk_rise = sclk_s && !sclk_d;
  assign sclk_fall = !sclk_s && sclk_d;
  assign ssel_rise = ssel_n_s && !ssel_n_d;
  assign ssel_fall = !ssel_n_s && ssel_n_d;

  // Port selection, strap caught three cycles after release
  sphp_port_t port_state;
  logic [1:0] boot_wait;
  logic strap_taken;
  logic strap_low;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_wait <= '0;
      strap_taken <= 1'b0;
      strap_low <= 1'b0;
    end else if (boot_wait != 2'd2) begin
      // Synchroniser shows its reset level for two edges after release
      boot_wait <= boot_wait + 2'd1;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      strap_low <= !dout_s;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_state <= SPHP_PORT_WAIT;
    end else begin
      unique case (port_state)
        SPHP_PORT_WAIT: begin
          if (strap_taken) begin
            if (strap_low || port_enable_in == SPHP_SEL_SYNC) begin
              port_state <= SPHP_PORT_SYNC;
            end else begin
              port_state <= SPHP_PORT_ASYNC;
            end
          end
        end
        SPHP_PORT_ASYNC: begin
          // Select only moves us across when both ports are enabled
          if (port_enable_in == SPHP_SEL_BOTH && ssel_fall) begin
            port_state <= SPHP_PORT_SYNC;
          end
        end
        SPHP_PORT_SYNC: begin
          port_state <= SPHP_PORT_SYNC;
        end
      endcase
    end
  end
  logic sync_on;
  assign sync_on = (port_state == SPHP_PORT_SYNC) &&
                   (framed_protocol_setting_in == SPHP_API_SETTING);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_active_out <= 1'b0;
      async_active_out <= 1'b0;
    end else begin
      sync_active_out <= port_state == SPHP_PORT_SYNC;
      async_active_out <= port_state == SPHP_PORT_ASYNC;
    end
  end

  // Transmit buffer
  logic fifo_rd_valid;
  logic [7:0] fifo_rd_data;
  logic fifo_rd_ready;
  sphp_fifo #(.WIDTH(SPHP_BYTE_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .wr_valid_in(tx_valid_in),
    .wr_data_in(tx_data_in),
    .wr_ready_out(tx_ready_out),
    .rd_valid_out(fifo_rd_valid),
    .rd_data_out(fifo_rd_data),
    .rd_ready_in(fifo_rd_ready)
  );

  // Padding owed when data lands in an empty buffer
  logic pad_owed;
  logic byte_load;
  logic load_due;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_owed <= 1'b0;
    end else if (tx_valid_in && tx_ready_out && !fifo_rd_valid) begin
      pad_owed <= 1'b1;
    end else if (byte_load && pad_owed) begin
      pad_owed <= 1'b0;
    end
  end

  // Shift engine
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic [2:0] bit_cnt;
  logic active;
  assign active = sync_on && !ssel_n_s;
  // Next byte is loaded on select assertion and after every eighth rising edge
  assign byte_load = sync_on && (ssel_fall || (active && sclk_fall && bit_cnt == 3'd0 &&
                     load_due));
  assign fifo_rd_ready = byte_load && !pad_owed && fifo_rd_valid;
  logic [7:0] next_byte;
  always_comb begin
    if (pad_owed) begin
      next_byte = SPHP_PAD_BYTE;
    end else if (fifo_rd_valid) begin
      next_byte = fifo_rd_data;
    end else begin
      next_byte = SPHP_BUSY_FILL;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_due <= 1'b0;
    end else if (ssel_rise || byte_load) begin
      load_due <= 1'b0;
    end else if (active && sclk_rise && bit_cnt == 3'd7) begin
      load_due <= 1'b1;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_shift <= SPHP_BUSY_FILL;
    end else if (ssel_rise) begin
      tx_shift <= SPHP_BUSY_FILL;
    end else if (byte_load) begin
      tx_shift <= next_byte;
    end else if (active && sclk_fall) begin
      tx_shift <= {tx_shift[6:0], 1'b1};
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_shift <= '0;
      bit_cnt <= '0;
    end else if (ssel_rise) begin
      rx_shift <= '0;
      bit_cnt <= '0;
    end else if (active && sclk_rise) begin
      rx_shift <= {rx_shift[6:0], mosi_s};
      bit_cnt <= bit_cnt + 3'd1;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_valid_out <= 1'b0;
      rx_data_out <= '0;
    end else begin
      rx_valid_out <= active && sclk_rise && bit_cnt == 3'd7;
      if (active && sclk_rise && bit_cnt == 3'd7) begin
        rx_data_out <= {rx_shift[6:0], mosi_s};
      end
    end
  end

  // Alert stays low until the last real byte has left the serializer
  logic data_in_shift;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_in_shift <= 1'b0;
    end else if (ssel_rise) begin
      data_in_shift <= 1'b0;
    end else if (byte_load) begin
      data_in_shift <= fifo_rd_ready;
    end
  end

  // Pin drivers; output enable held while clock toggles
  logic sclk_seen;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_seen <= 1'b0;
      miso_out <= 1'b1;
      miso_oe_out <= 1'b0;
      data_pending_alert_n_out <= 1'b1;
    end else begin
      if (sync_on && (sclk_rise || sclk_fall)) begin
        sclk_seen <= 1'b1;
      end
      miso_out <= tx_shift[7];
      miso_oe_out <= sync_on && (!ssel_n_s || sclk_seen);
      data_pending_alert_n_out <= !(sync_on &&
                                    (fifo_rd_valid || pad_owed || data_in_shift));
    end
  end

  // Assertions
  logic [7:0] past_rx;
  always_ff @(posedge clock_in) begin
    past_rx <= rx_shift;
  end
  property p_alert;
    @(posedge clock_in) disable iff (!rst_n_in)
      (sync_on && fifo_rd_valid) |=> !data_pending_alert_n_out;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not raised with data");
  property p_ssel_clear;
    @(posedge clock_in) disable iff (!rst_n_in)
      ssel_rise |=> (rx_shift == 8'h00 && bit_cnt == 3'd0);
  endproperty
  a_ssel_clear: assert property (p_ssel_clear) else $error("shift not cleared");
  property p_fill;
    @(posedge clock_in) disable iff (!rst_n_in)
      (byte_load && !pad_owed && !fifo_rd_valid) |=> tx_shift == SPHP_BUSY_FILL;
  endproperty
  a_fill: assert property (p_fill) else $error("fill byte wrong");
  property p_pad;
    @(posedge clock_in) disable iff (!rst_n_in)
      (tx_valid_in && tx_ready_out && !fifo_rd_valid) |=> pad_owed;
  endproperty
  a_pad: assert property (p_pad) else $error("padding not owed");
  property p_sync_sticky;
    @(posedge clock_in) disable iff (!rst_n_in)
      port_state == SPHP_PORT_SYNC |=> port_state == SPHP_PORT_SYNC;
  endproperty
  a_sync_sticky: assert property (p_sync_sticky) else $error("left sync port");
  property p_async_only;
    @(posedge clock_in) disable iff (!rst_n_in)
      (port_state == SPHP_PORT_ASYNC && port_enable_in != SPHP_SEL_BOTH)
      |=> port_state == SPHP_PORT_ASYNC;
  endproperty
  a_async_only: assert property (p_async_only) else $error("select not ignored");
  property p_strap;
    @(posedge clock_in) disable iff (!rst_n_in)
      (port_state == SPHP_PORT_WAIT && strap_taken && strap_low) |=> port_state == SPHP_PORT_SYNC;
  endproperty
  a_strap: assert property (p_strap) else $error("strap ignored");
  property p_msb;
    @(posedge clock_in) disable iff (!rst_n_in)
      (active && sclk_rise) |=> rx_shift[0] == $past(mosi_s) && rx_shift[7:1] == past_rx[6:0];
  endproperty
  a_msb: assert property (p_msb) else $error("receive order wrong");
  property p_oe;
    @(posedge clock_in) disable iff (!rst_n_in)
      (sync_on && !ssel_n_s) |=> miso_oe_out;
  endproperty
  a_oe: assert property (p_oe) else $error("output not driven");
  property p_alert_shift;
    @(posedge clock_in) disable iff (!rst_n_in)
      (sync_on && data_in_shift) |=> !data_pending_alert_n_out;
  endproperty
  a_alert_shift: assert property (p_alert_shift) else $error("alert dropped early");
  c_rx_byte: cover property (@(posedge clock_in) disable iff (!rst_n_in) rx_valid_out);
  c_to_sync: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(port_state == SPHP_PORT_SYNC));
  c_pad_sent: cover property (@(posedge clock_in) disable iff (!rst_n_in) byte_load && pad_owed);
endmodule : sphp_spi_slave
`default_nettype wire

// ---- shared/sphp_pkg.sv ----
// Shared constants and carrier types for the host serial port block
package sphp_pkg;
  localparam int SPHP_BYTE_W = 8;
  localparam logic [7:0] SPHP_BUSY_FILL = 8'hFF;
  localparam logic [7:0] SPHP_PAD_BYTE = 8'hFF;
  localparam int SPHP_FIFO_DEPTH = 16;
  localparam logic SPHP_API_SETTING = 1'b1;
  localparam int SPHP_CLK_HZ = 20_000_000;
  localparam int SPHP_MAX_BPS = 5_000_000;
  localparam int SPHP_MIN_SCLK_CYC = SPHP_CLK_HZ / SPHP_MAX_BPS;
  localparam logic [1:0] SPHP_SEL_ASYNC = 2'b01;
  localparam logic [1:0] SPHP_SEL_SYNC = 2'b10;
  localparam logic [1:0] SPHP_SEL_BOTH = 2'b11;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sphp_byte_t;
  typedef enum logic [2:0] {
    SPHP_PORT_WAIT = 3'b001,
    SPHP_PORT_ASYNC = 3'b010,
    SPHP_PORT_SYNC = 3'b100
  } sphp_port_t;
endpackage : sphp_pkg

// ---- rtl/sphp_sync2.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sphp_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Data
  input wire logic d_in,
  output logic q_out
);
  logic meta;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= RESET_VAL;
      q_out <= RESET_VAL;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule : sphp_sync2
`default_nettype wire

// ---- rtl/sphp_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sphp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic wr_ready_out,
  // Drain side
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // Pointers wrap by overflow, so only powers of two are served
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic do_wr;
  logic do_rd;
  assign rd_valid_out = (count != '0);
  assign rd_data_out = mem[rd_ptr];
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;
  assign next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  always_ff @(posedge clock_in) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      wr_ready_out <= 1'b1;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + AW'(1);
      if (do_rd) rd_ptr <= rd_ptr + AW'(1);
      count <= next_count;
      // Ready is registered from the next count, so it equals count below depth
      wr_ready_out <= next_count != (AW+1)'(DEPTH);
    end
  end
endmodule : sphp_fifo
`default_nettype wire

// ---- dv/sphp_spi_master.sv ----
// Master side model of the host serial link
`timescale 1ns/100ps
`default_nettype none
module sphp_spi_master #(
  parameter int HALF = 4
) (
  // Clock
  input wire logic clock_in,
  // Serial pins
  output logic sclk_out,
  output logic mosi_out,
  output logic ssel_n_out,
  input wire logic miso_in,
  input wire logic miso_oe_in
);
  // Extra cycles per half period for a slow master
  int stretch = 0;
  initial begin
    sclk_out = 1'b0;
    mosi_out = 1'b1;
    ssel_n_out = 1'b1;
  end
  // Gap after select lets the first byte load before the first rise
  task automatic sel();
    ssel_n_out = 1'b0;
    repeat (2 * HALF) @(posedge clock_in);
    #1;
  endtask : sel
  // A released data line does not keep its last bit; the gap lets the device drain
  task automatic desel();
    ssel_n_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (2 * HALF) @(posedge clock_in);
    #1;
  endtask : desel
  // Half periods of HALF cycles stay well inside the rate ceiling
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      mosi_out = tx[i];
      repeat (HALF + stretch) @(posedge clock_in);
      #1;
      sclk_out = 1'b1;
      rx = {rx[6:0], (miso_oe_in === 1'b1) ? miso_in : 1'bx};
      repeat (HALF + stretch) @(posedge clock_in);
      #1;
      sclk_out = 1'b0;
    end
  endtask : xfer
endmodule : sphp_spi_master
`default_nettype wire

// ---- dv/spi_slave_host_port_select_tb_top.sv ----
// Self-checking bench for the host serial port block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module spi_slave_host_port_select_tb_top;
  import sphp_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] port_enable = 2'b11;
  logic async_pin = 1'b1;
  logic framed = 1'b1;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  wire logic sclk, mosi, ssel_n, miso, miso_oe, alert_n, tx_ready, rx_valid, sync_act, async_act;
  wire logic [7:0] rx_data;
  logic [7:0] r;
  logic [7:0] rxq[$];
  // Entries are port enable, boot pin level, expected sync use
  logic [3:0] tbl[4] = '{4'h6, 4'h2, 4'hB, 4'hD};
  int err_total = 0;
  int checks_done = 0;
  always #25 clock_in = ~clock_in;
  // Framed setting is driven so that its refusal can be seen
  sphp_spi_slave DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .mosi_in(mosi),
    .ssel_n_in(ssel_n), .miso_out(miso), .miso_oe_out(miso_oe),
    .data_pending_alert_n_out(alert_n), .port_enable_in(port_enable),
    .async_dout_pin_in(async_pin), .framed_protocol_setting_in(framed),
    .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(tx_ready),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .sync_active_out(sync_act),
    .async_active_out(async_act));
  sphp_spi_master M (.clock_in(clock_in), .sclk_out(sclk), .mosi_out(mosi),
    .ssel_n_out(ssel_n), .miso_in(miso), .miso_oe_in(miso_oe));
  always @(posedge clock_in) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
  end
  task automatic give_verdict();
    $display("checks_done %0d err_total %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic done(input string name);
    $display("test %s finished", name);
    rxq.delete();
  endtask : done
  // Boot pins are held through reset so the strap is seen
  task automatic reboot(input logic [1:0] pe, input logic pin);
    rst_n_in = 1'b0;
    port_enable = pe;
    async_pin = pin;
    repeat (4) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    rxq.delete();
    // Strap crosses two flip-flops before the port choice settles
    repeat (6) @(posedge clock_in);
    #1;
  endtask : reboot
  // Valid stays high between pushes; the caller lowers it
  task automatic push(input logic [7:0] d);
    int n;
    n = 0;
    tx_valid = 1'b1;
    tx_data = d;
    do begin
      @(posedge clock_in);
      n++;
    end while (tx_ready !== 1'b1 && n < 50);
    #1;
  endtask : push
  task automatic xchg(input logic [7:0] tx, input logic [7:0] e);
    M.xfer(tx, 8, r);
    `CHK(r, e)
  endtask : xchg
  task automatic rx_is(input logic [7:0] e);
    logic [7:0] got;
    `CHK(rxq.size(), 1)
    if (rxq.size() > 0) begin
      got = rxq.pop_front();
      `CHK(got, e)
    end
  endtask : rx_is
  initial begin
    repeat (20000) @(posedge clock_in);
    err_total++;
    give_verdict();
  end
  initial begin
    reboot(2'b11, 1'b1);
    `CHK({async_act, sync_act, alert_n, miso_oe}, 4'hA)
    M.sel();
    xchg(8'hA5, SPHP_BUSY_FILL);
    M.desel();
    rx_is(8'hA5);
    `CHK({async_act, sync_act}, 2'b01)
    done("busy_fill");
    push(8'h3C);
    push(8'h81);
    tx_valid = 1'b0;
    @(posedge clock_in);
    #1;
    `CHK(alert_n, 1'b0)
    M.sel();
    xchg(8'h11, SPHP_PAD_BYTE);
    xchg(8'h22, 8'h3C);
    xchg(8'h33, 8'h81);
    M.desel();
    `CHK(alert_n, 1'b1)
    done("pad_byte");
    for (int i = 0; i < SPHP_FIFO_DEPTH; i++) push(8'h40 + i[7:0]);
    tx_valid = 1'b0;
    `CHK(tx_ready, 1'b0)
    M.stretch = 4;
    M.sel();
    xchg(8'h00, SPHP_PAD_BYTE);
    for (int i = 0; i < SPHP_FIFO_DEPTH; i++) xchg(8'h00, 8'h40 + i[7:0]);
    M.desel();
    M.stretch = 0;
    `CHK({tx_ready, alert_n}, 2'b11)
    done("full_buffer");
    M.sel();
    M.xfer(8'hF0, 4, r);
    M.desel();
    M.sel();
    xchg(8'h5A, SPHP_BUSY_FILL);
    M.desel();
    rx_is(8'h5A);
    M.xfer(8'hC3, 8, r);
    `CHK(miso_oe, 1'b1)
    `CHK(rxq.size(), 0)
    done("select_abort");
    for (int k = 0; k < 4; k++) begin
      reboot(tbl[k][3:2], tbl[k][1]);
      `CHK({sync_act, async_act}, {tbl[k][0], ~tbl[k][0]})
      M.sel();
      M.xfer(8'h66, 8, r);
      M.desel();
      `CHK({sync_act, miso_oe}, {2{tbl[k][0]}})
      `CHK(rxq.size(), int'(tbl[k][0]))
    end
    framed = 1'b0;
    reboot(2'b10, 1'b1);
    M.sel();
    M.xfer(8'h77, 8, r);
    M.desel();
    `CHK({sync_act, miso_oe}, 2'b10)
    `CHK(rxq.size(), 0)
    framed = 1'b1;
    done("port_select");
    give_verdict();
  end
endmodule : spi_slave_host_port_select_tb_top
`default_nettype wire
